// ===== hdl/hiop_pkg.sv
// Package: constants, register map and sequencer states for the handler I/O port
package hiop_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] HIOP_OUT_OFS = 8'h00;
  localparam logic [7:0] HIOP_SAMPLE_OFS = 8'h04;
  localparam logic [7:0] HIOP_STORED_OFS = 8'h08;
  localparam logic [7:0] HIOP_DIRECT_OFS = 8'h0c;
  localparam logic [7:0] HIOP_CTRL_OFS = 8'h10;
  localparam logic [7:0] HIOP_STATUS_OFS = 8'h14;
  localparam logic [7:0] HIOP_INT_STAT_OFS = 8'h18;
  localparam logic [7:0] HIOP_INT_EN_OFS = 8'h1c;
  localparam logic [7:0] HIOP_INT_CLR_OFS = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int HIOP_CTRL_LIMIT_BIT = 0;
  localparam int HIOP_CTRL_TRIG_BIT = 1;
  localparam int HIOP_INT_DONE_BIT = 0;
  localparam int HIOP_INT_TRIG_BIT = 1;
  localparam int HIOP_INT_W = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] HIOP_OUT_RST = 8'h00;
  localparam logic HIOP_PF_RST = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int HIOP_CLK_MHZ = 25;
  localparam int HIOP_DONE_MIN_NS = 1600;
  // Strictly longer than the minimum, so one cycle is added
  localparam int HIOP_DONE_CYC = (HIOP_DONE_MIN_NS * HIOP_CLK_MHZ + 999)
                                 / 1000 + 1;
  localparam int HIOP_MEAS_CYC = 16;

  typedef enum logic [1:0] {
    HIOP_IDLE,
    HIOP_MEAS,
    HIOP_PULSE
  } hiop_state_t;

endpackage

// ===== hdl/hiop_pulse.sv
// Module: fixed-width low-going pulse generator
`timescale 1ns/1ns
`default_nettype none
module hiop_pulse import hiop_pkg::*; #(
  parameter int WIDTH_CYC = HIOP_DONE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output var logic busy,
  output var logic pulse_n
);

  logic [7:0] cnt_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
      pulse_n <= 1'b1;
      busy <= 1'b0;
    end else if (start && !busy) begin
      cnt_ff <= 8'(WIDTH_CYC - 1);
      pulse_n <= 1'b0;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_ff == 8'h00) begin
        pulse_n <= 1'b1;
        busy <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/hiop_top.sv
// Module: handler I/O port with APB register access
`timescale 1ns/1ns
`default_nettype none
module hiop_top import hiop_pkg::*; #(
  parameter int MEAS_CYC = HIOP_MEAS_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic [31:0] prdata,
  output var logic pready,
  output var logic pslverr,
  // Handler port
  input wire logic [3:0] port_in,
  input wire logic trigger_in,
  output var logic [7:0] port_out,
  output var logic sweep_done_n,
  output var logic pass_fail,
  // Measurement result
  input wire logic meas_pass,
  // Interrupt
  output var logic irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff, rst_n_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access, wr, rd, hit;
  assign access = psel && penable;
  // Writes commit on the completing edge, when pready is sampled high
  assign wr = access && pwrite && pready;
  assign rd = access && !pwrite;
  always_comb begin
    unique case (paddr)
      HIOP_OUT_OFS, HIOP_SAMPLE_OFS, HIOP_STORED_OFS, HIOP_DIRECT_OFS,
      HIOP_CTRL_OFS, HIOP_STATUS_OFS, HIOP_INT_STAT_OFS, HIOP_INT_EN_OFS,
      HIOP_INT_CLR_OFS: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Output latch, input store and limit enable
  // ----------------------------------------------------------------
  logic [3:0] nibble_ff;
  logic limit_en_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      port_out <= HIOP_OUT_RST;
    end else if (wr && paddr == HIOP_OUT_OFS) begin
      port_out <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      nibble_ff <= 4'h0;
    end else if (wr && paddr == HIOP_SAMPLE_OFS) begin
      nibble_ff <= port_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      limit_en_ff <= 1'b0;
    end else if (wr && paddr == HIOP_CTRL_OFS) begin
      limit_en_ff <= pwdata[HIOP_CTRL_LIMIT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sweep sequencer
  // ----------------------------------------------------------------
  hiop_state_t state_ff;
  logic [7:0] meas_cnt_ff;
  logic trig_d_ff, trig_rise, sw_trig, pulse_start, pulse_busy;
  assign trig_rise = trigger_in && !trig_d_ff;
  assign sw_trig = wr && paddr == HIOP_CTRL_OFS && pwdata[HIOP_CTRL_TRIG_BIT];
  assign pulse_start = state_ff == HIOP_MEAS && meas_cnt_ff == 8'h00;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      trig_d_ff <= 1'b0;
    end else begin
      trig_d_ff <= trigger_in;
    end
  end

  // Triggers during a sweep are ignored; the handler waits for the pulse
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= HIOP_IDLE;
      meas_cnt_ff <= 8'h00;
    end else begin
      unique case (state_ff)
        HIOP_IDLE: begin
          if (trig_rise || sw_trig) begin
            state_ff <= HIOP_MEAS;
            meas_cnt_ff <= 8'(MEAS_CYC - 1);
          end
        end
        HIOP_MEAS: begin
          if (meas_cnt_ff == 8'h00) begin
            state_ff <= HIOP_PULSE;
          end else begin
            meas_cnt_ff <= meas_cnt_ff - 8'h01;
          end
        end
        HIOP_PULSE: begin
          if (!pulse_busy) begin
            state_ff <= HIOP_IDLE;
          end
        end
        default: state_ff <= HIOP_IDLE;
      endcase
    end
  end

  hiop_pulse #(
    .WIDTH_CYC(HIOP_DONE_CYC)
  ) u_pulse (
    .clk(clk),
    .rst_n(rst_n_ff),
    .start(pulse_start),
    .busy(pulse_busy),
    .pulse_n(sweep_done_n)
  );

  // Result is latched with the pulse so the handler sees it settled
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pass_fail <= HIOP_PF_RST;
    end else if (pulse_start && limit_en_ff) begin
      pass_fail <= meas_pass;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [HIOP_INT_W-1:0] int_stat_ff, int_en_ff, int_set, int_clr;
  assign int_set = {trig_rise && state_ff == HIOP_IDLE, pulse_start};
  assign int_clr = (wr && paddr == HIOP_INT_CLR_OFS) ?
                   pwdata[HIOP_INT_W-1:0] : '0;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      int_stat_ff <= '0;
    end else begin
      // Set wins over a clear in the same cycle
      int_stat_ff <= (int_stat_ff & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      int_en_ff <= '0;
    end else if (wr && paddr == HIOP_INT_EN_OFS) begin
      int_en_ff <= pwdata[HIOP_INT_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat_ff & ~int_clr) | int_set) & int_en_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0;
    unique case (paddr)
      HIOP_OUT_OFS: nxt_rdata = {24'h0, port_out};
      HIOP_STORED_OFS: nxt_rdata = {28'h0, nibble_ff};
      HIOP_DIRECT_OFS: nxt_rdata = {28'h0, port_in};
      HIOP_CTRL_OFS: nxt_rdata = {31'h0, limit_en_ff};
      HIOP_STATUS_OFS: nxt_rdata = {29'h0, pass_fail, sweep_done_n,
                                    state_ff != HIOP_IDLE};
      HIOP_INT_STAT_OFS: nxt_rdata = {30'h0, int_stat_ff};
      HIOP_INT_EN_OFS: nxt_rdata = {30'h0, int_en_ff};
      default: nxt_rdata = 32'h0;
    endcase
  end

  // Two-cycle access: pready is registered so every output is a flop
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= (rd && !pready) ? nxt_rdata : 32'h0;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Length of the current low phase, so the width check needs no
  // long repetition; saturates rather than wrapping on a stuck line
  logic [7:0] low_run_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      low_run_ff <= 8'h00;
    end else if (sweep_done_n) begin
      low_run_ff <= 8'h00;
    end else if (low_run_ff != 8'hff) begin
      low_run_ff <= low_run_ff + 8'h01;
    end
  end

  property p_pulse_width;
    @(posedge clk) disable iff (!rst_n_ff)
    $rose(sweep_done_n) |->
      int'(low_run_ff) * 1000 > HIOP_DONE_MIN_NS * HIOP_CLK_MHZ;
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("sweep pulse too short");

  property p_out_hold;
    @(posedge clk) disable iff (!rst_n_ff)
    !(wr && paddr == HIOP_OUT_OFS) |=> $stable(port_out);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("output latch changed without write");

  property p_out_write;
    @(posedge clk) disable iff (!rst_n_ff)
    wr && paddr == HIOP_OUT_OFS |=> port_out == $past(pwdata[7:0]);
  endproperty
  a_out_write: assert property (p_out_write)
    else $error("output latch wrong value");

  property p_sample;
    @(posedge clk) disable iff (!rst_n_ff)
    wr && paddr == HIOP_SAMPLE_OFS |=> nibble_ff == $past(port_in);
  endproperty
  a_sample: assert property (p_sample)
    else $error("input nibble not stored");

  property p_sample_hold;
    @(posedge clk) disable iff (!rst_n_ff)
    !(wr && paddr == HIOP_SAMPLE_OFS) |=> $stable(nibble_ff);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("input nibble changed without sample");

  property p_stored_read;
    @(posedge clk) disable iff (!rst_n_ff)
    rd && !pready && paddr == HIOP_STORED_OFS
      |=> prdata == {28'h0, $past(nibble_ff)};
  endproperty
  a_stored_read: assert property (p_stored_read)
    else $error("stored query wrong");

  property p_direct_read;
    @(posedge clk) disable iff (!rst_n_ff)
    rd && !pready && paddr == HIOP_DIRECT_OFS
      |=> prdata == {28'h0, $past(port_in)};
  endproperty
  a_direct_read: assert property (p_direct_read)
    else $error("direct query wrong");

  property p_pf_hold;
    @(posedge clk) disable iff (!rst_n_ff)
    !limit_en_ff |=> $stable(pass_fail);
  endproperty
  a_pf_hold: assert property (p_pf_hold)
    else $error("pass/fail moved with limit off");

  property p_pf_value;
    @(posedge clk) disable iff (!rst_n_ff)
    pulse_start && limit_en_ff |=> pass_fail == $past(meas_pass);
  endproperty
  a_pf_value: assert property (p_pf_value)
    else $error("pass/fail wrong level");

  property p_trig_pulse;
    @(posedge clk) disable iff (!rst_n_ff)
    state_ff == HIOP_IDLE && trig_rise |-> ##[1:300] $fell(sweep_done_n);
  endproperty
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("no sweep pulse after trigger");

  property p_sw_pulse;
    @(posedge clk) disable iff (!rst_n_ff)
    state_ff == HIOP_IDLE && sw_trig |-> ##[1:300] $fell(sweep_done_n);
  endproperty
  a_sw_pulse: assert property (p_sw_pulse)
    else $error("no sweep pulse after software start");

  property p_pf_when;
    @(posedge clk) disable iff (!rst_n_ff)
    $changed(pass_fail) |-> $past(pulse_start) && $past(limit_en_ff);
  endproperty
  a_pf_when: assert property (p_pf_when)
    else $error("pass/fail moved outside a limit-tested sweep end");

  property p_rest_high;
    @(posedge clk) disable iff (!rst_n_ff)
    state_ff == HIOP_IDLE && !pulse_busy |-> sweep_done_n;
  endproperty
  a_rest_high: assert property (p_rest_high)
    else $error("sweep line not resting high");

  c_sweep: cover property (@(posedge clk) disable iff (!rst_n_ff)
    $rose(sweep_done_n));
  c_fail: cover property (@(posedge clk) disable iff (!rst_n_ff)
    $fell(pass_fail));
  c_irq: cover property (@(posedge clk) disable iff (!rst_n_ff) $rose(irq));
  c_sw_start: cover property (@(posedge clk) disable iff (!rst_n_ff)
    sw_trig && state_ff == HIOP_IDLE);
  c_pass: cover property (@(posedge clk) disable iff (!rst_n_ff)
    $rose(pass_fail));

endmodule
`default_nettype wire

// ===== dv/hiop_handler_model.sv
// Behavioural model of the production-line handler
`timescale 1ns/1ns
`default_nettype none
module hiop_handler_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench command
  input wire logic go,
  // Device port
  input wire logic sweep_done_n,
  input wire logic pass_fail,
  output var logic trigger_in,
  output var logic bin_pass
);
  logic [1:0] cnt_ff;
  logic done_q_ff;

  // ------------------------------------------------------------
  // Trigger pulse and binning
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 2'h0;
      trigger_in <= 1'b0;
      bin_pass <= 1'b0;
      done_q_ff <= 1'b1;
    end else begin
      if (go && cnt_ff == 2'h0) begin
        cnt_ff <= 2'h3;
      end else if (cnt_ff != 2'h0) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
      trigger_in <= (cnt_ff != 2'h0);
      done_q_ff <= sweep_done_n;
      // Bin on the rising end of the pulse, when the level is settled
      if (sweep_done_n && !done_q_ff) begin
        bin_pass <= pass_fail;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench for the handler I/O port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import hiop_pkg::*;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, trigger_in, sweep_done_n, pass_fail;
  logic [3:0] port_in = 4'h0;
  logic meas_pass = 0, go = 0, irq, bin_pass;
  logic [7:0] port_out;
  int mismatches = 0, tests_run = 0, cycles = 0;
  logic [7:0] vals [4] = '{8'ha5, 8'h5a, 8'hff, 8'h01};

  hiop_top #(.MEAS_CYC(4)) DUT (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port_in), .trigger_in(trigger_in), .port_out(port_out),
    .sweep_done_n(sweep_done_n), .pass_fail(pass_fail),
    .meas_pass(meas_pass), .irq(irq));
  hiop_handler_model handler (.clk(clk), .resetn(resetn), .go(go),
    .sweep_done_n(sweep_done_n), .pass_fail(pass_fail),
    .trigger_in(trigger_in), .bin_pass(bin_pass));

  initial begin
    forever #20 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Closing and hang guard
  // ------------------------------------------------------------
  task end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim;
    end
  end

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Start a sweep by handler pulse or by software, then time the pulse
  task sweep(input logic hw, input logic pass, input logic [31:0] ctrl);
    int n;
    meas_pass <= pass;
    if (hw) begin
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
    end else begin
      apb(1'b1, HIOP_CTRL_OFS, ctrl | 32'h2);
    end
    n = 0;
    while (sweep_done_n !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (sweep_done_n !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n * 40 > 1600 && n < 100, 1);
    repeat (3) @(posedge clk);
    chk(sweep_done_n, 1);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(port_out, 0);
    chk(sweep_done_n, 1);
    chk(pass_fail, HIOP_PF_RST);
    rd(HIOP_STATUS_OFS, 32'h6);
    chk(e, 0);
    foreach (vals[i]) begin
      apb(1'b1, HIOP_OUT_OFS, {24'h0, vals[i]});
      chk(port_out, vals[i]);
      rd(HIOP_OUT_OFS, vals[i]);
    end
    for (int k = 0; k < 2; k++) begin
      port_in <= k ? 4'hf : 4'h9;
      @(posedge clk);
      apb(1'b1, HIOP_SAMPLE_OFS, 32'h0);
      port_in <= k ? 4'h0 : 4'h6;
      @(posedge clk);
      rd(HIOP_STORED_OFS, k ? 32'hf : 32'h9);
      rd(HIOP_DIRECT_OFS, k ? 32'h0 : 32'h6);
    end
    chk(port_out, 8'h01);
    apb(1'b0, 8'h24, 32'h0);
    chk({r[31:1], e}, 1);
    apb(1'b1, HIOP_INT_EN_OFS, 32'h1);
    apb(1'b1, HIOP_CTRL_OFS, 32'h1);
    sweep(1'b1, 1'b0, 32'h1);
    chk(pass_fail, 0);
    chk(bin_pass, 0);
    chk(irq, 1);
    apb(1'b0, HIOP_INT_STAT_OFS, 32'h0);
    chk(r, 32'h3);
    apb(1'b1, HIOP_INT_CLR_OFS, 32'h3);
    chk(irq, 0);
    rd(HIOP_INT_STAT_OFS, 0);
    apb(1'b1, HIOP_INT_EN_OFS, 32'h0);
    sweep(1'b0, 1'b1, 32'h1);
    chk(pass_fail, 1);
    chk(irq, 0);
    apb(1'b1, HIOP_INT_CLR_OFS, 32'h3);
    apb(1'b1, HIOP_CTRL_OFS, 32'h0);
    sweep(1'b1, 1'b0, 32'h0);
    chk(pass_fail, 1);
    chk(bin_pass, 1);
    chk(port_out, 8'h01);
    apb(1'b1, HIOP_CTRL_OFS, 32'h1);
    rd(HIOP_CTRL_OFS, 32'h1);
    sweep(1'b1, 1'b0, 32'h1);
    chk({pass_fail, bin_pass}, 0);
    end_sim;
  end
endmodule
`default_nettype wire
